// >>> cbsrp_defines.vh
// Constants for the scanned BCD rear port
`ifndef CBSRP_DEFINES_VH
`define CBSRP_DEFINES_VH
`define CBSRP_CLK_HZ 20000000
`define CBSRP_DIGITS 5
`define CBSRP_SCAN_HZ 2000
`define CBSRP_SCAN_HALF (`CBSRP_CLK_HZ / (2 * `CBSRP_SCAN_HZ))
`define CBSRP_BLINK_HZ 3
`define CBSRP_BLINK_HALF (`CBSRP_CLK_HZ / (2 * `CBSRP_BLINK_HZ))
`define CBSRP_STROBE_NS 500
`define CBSRP_CLK_NS 50
`define CBSRP_STROBE_CYC ((`CBSRP_STROBE_NS + `CBSRP_CLK_NS - 1) / `CBSRP_CLK_NS)
`define CBSRP_POR_CYC 16
`define CBSRP_FIFO_DEPTH 16
`define CBSRP_FIFO_AW 4
`endif

// >>> cbsrp_port.v
// Scanned BCD rear port of a counter, with count FIFO
`timescale 1ns/10ps
`include "cbsrp_defines.vh"

// ==========================================================================
// FIFO
module cbsrp_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  clk_sys,
  nrst,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input clk_sys;
  input nrst;
  input in_valid;
  output in_ready;
  input [WIDTH-1:0] in_data;
  output out_valid;
  input out_ready;
  output [WIDTH-1:0] out_data;
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  // Count is one bit wider than the pointers so full and empty differ
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // cbsrp_fifo

// ==========================================================================
// Top
module cbsrp_port (
  clk_sys,
  nrst,
  count_in,
  count_ovf,
  gate_end,
  tally_mode,
  dp_active,
  zero_supp,
  clear_in,
  clear_out,
  clear_oe,
  ovf_in,
  ovf_out,
  ovf_oe,
  manual_gate_n,
  scan_dis_n,
  fifo_ready,
  int_clear,
  counter_clear,
  gate_open,
  display_blank,
  display_q,
  scan_clk_out,
  bcd_out,
  dp_out_n,
  sync_out_n,
  latch_strobe
);
  input clk_sys;
  input nrst;
  input [19:0] count_in;
  input count_ovf;
  input gate_end;
  input tally_mode;
  input [4:0] dp_active;
  input zero_supp;
  input clear_in;
  output clear_out;
  output clear_oe;
  input ovf_in;
  output ovf_out;
  output ovf_oe;
  input manual_gate_n;
  input scan_dis_n;
  output fifo_ready;
  input int_clear;
  output counter_clear;
  output gate_open;
  output display_blank;
  output [19:0] display_q;
  output scan_clk_out;
  output [3:0] bcd_out;
  output [4:0] dp_out_n;
  output sync_out_n;
  output latch_strobe;

  localparam S_IDLE = 2'b01;
  localparam S_PULSE = 2'b10;
  // Macro values are 32 bits; each is cut to its counter's width on purpose
  localparam integer SCAN_HALF_I = `CBSRP_SCAN_HALF;
  localparam integer BLINK_HALF_I = `CBSRP_BLINK_HALF;
  localparam integer STROBE_CYC_I = `CBSRP_STROBE_CYC;
  localparam integer POR_CYC_I = `CBSRP_POR_CYC;
  localparam integer DIGITS_I = `CBSRP_DIGITS;
  localparam [15:0] SCAN_HALF = SCAN_HALF_I[15:0];
  localparam [22:0] BLINK_HALF = BLINK_HALF_I[22:0];
  localparam [4:0] STROBE_CYC = STROBE_CYC_I[4:0];
  localparam [4:0] POR_CYC = POR_CYC_I[4:0];
  localparam [2:0] LAST_SLOT = DIGITS_I[2:0];

  // ========================================================================
  // Input synchronisers
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      s1_q <= 5'h1f;
      s2_q <= 5'h1f;
    end else begin
      s1_q <= {clear_in, ovf_in, manual_gate_n, scan_dis_n, 1'b1};
      s2_q <= s1_q;
    end
  end
  wire clear_s = s2_q[4];
  wire ovf_s = s2_q[3];
  wire mgate_s = s2_q[2];
  wire sdis_s = s2_q[1];

  // ========================================================================
  // Power-up clear pulse
  reg [4:0] por_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      por_q <= 5'h00;
    end else if (por_q != POR_CYC) begin
      por_q <= por_q + 5'h01;
    end
  end
  // Internal recount clears the counter but never pulls the pin
  assign clear_oe = (por_q != POR_CYC);
  assign clear_out = 1'b0;
  assign counter_clear = !clear_s | clear_oe | int_clear;
  // Manual gate only meaningful in tally mode; not locked out elsewhere
  assign gate_open = !mgate_s;

  // ========================================================================
  // Latch strobe and store; FIFO buffers stored counts, dropping any offered while full
  reg [1:0] st_q;
  reg [4:0] sc_q;
  reg strobe_q;
  reg strobe_dly_q;
  reg [19:0] display_q;
  reg [19:0] cap_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      sc_q <= 5'h00;
      strobe_q <= 1'b0;
      cap_q <= 20'h00000;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (tally_mode) begin
            strobe_q <= 1'b1;
          end else if (gate_end) begin
            st_q <= S_PULSE;
            strobe_q <= 1'b1;
            sc_q <= 5'h01;
            cap_q <= count_in;
          end else begin
            strobe_q <= 1'b0;
          end
        end
        S_PULSE: begin
          if (sc_q == STROBE_CYC) begin
            st_q <= S_IDLE;
            strobe_q <= 1'b0;
          end else begin
            sc_q <= sc_q + 5'h01;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  assign latch_strobe = strobe_q;
  wire strobe_rise = strobe_q & !strobe_dly_q;
  wire [19:0] store_src = tally_mode ? count_in : cap_q;
  wire push = strobe_rise | (tally_mode & strobe_q);
  wire [19:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      strobe_dly_q <= 1'b0;
      display_q <= 20'h00000;
    end else begin
      strobe_dly_q <= strobe_q;
      if (fifo_pop) begin
        display_q <= fifo_data;
      end
    end
  end
  // Store drains only at the sync slot so one scan shows a single count
  cbsrp_fifo #(
    .WIDTH(20),
    .DEPTH(`CBSRP_FIFO_DEPTH),
    .AW(`CBSRP_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(store_src),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ========================================================================
  // Scan clock and slot counter
  reg [15:0] div_q;
  reg sclk_q;
  reg [2:0] slot_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      div_q <= 16'h0000;
      sclk_q <= 1'b0;
      slot_q <= 3'h0;
    // Clock and slot hold when disabled and the divider clears, so the scan resumes where it stopped
    end else if (!sdis_s) begin
      div_q <= 16'h0000;
    end else if (div_q == SCAN_HALF - 16'h0001) begin
      div_q <= 16'h0000;
      sclk_q <= !sclk_q;
      if (!sclk_q) begin
        slot_q <= (slot_q == LAST_SLOT) ? 3'h0 : slot_q + 3'h1;
      end
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign scan_clk_out = sclk_q;
  // Pops only while scanning; a stopped scan keeps its count on show
  assign fifo_pop = fifo_valid & (slot_q == 3'h0) & sdis_s;

  // ========================================================================
  // Digit outputs, registered per slot
  function [3:0] digit_of;
    input [19:0] v;
    input [2:0] s;
    begin
      case (s)
        3'h1: digit_of = v[19:16];
        3'h2: digit_of = v[15:12];
        3'h3: digit_of = v[11:8];
        3'h4: digit_of = v[7:4];
        3'h5: digit_of = v[3:0];
        default: digit_of = 4'h0;
      endcase
    end
  endfunction
  // Outputs trail the slot by one cycle, long before the far side reads
  reg [3:0] bcd_q;
  reg [4:0] dpn_q;
  reg sync_n_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      bcd_q <= 4'h0;
      dpn_q <= 5'h1f;
      sync_n_q <= 1'b1;
    end else begin
      bcd_q <= digit_of(display_q, slot_q);
      dpn_q <= ~dp_active;
      sync_n_q <= (slot_q != 3'h0);
    end
  end
  assign bcd_out = bcd_q;
  assign dp_out_n = dpn_q;
  assign sync_out_n = sync_n_q;

  // ========================================================================
  // Overflow, blanking and zero suppression line
  reg [22:0] blink_q;
  reg blink_ph_q;
  always @(posedge clk_sys) begin
    if (!nrst || !count_ovf) begin
      blink_q <= 23'h000000;
      blink_ph_q <= 1'b1;
    end else if (blink_q == BLINK_HALF - 23'h000001) begin
      blink_q <= 23'h000000;
      blink_ph_q <= !blink_ph_q;
    end else begin
      blink_q <= blink_q + 23'h000001;
    end
  end
  // Open drain: only ever pulls low, far side may pull low to blank
  assign ovf_oe = count_ovf ? !blink_ph_q : zero_supp;
  assign ovf_out = 1'b0;
  // Our own pull reaches ovf_s two flops late; mask it for that long
  reg oe1_q;
  reg oe2_q;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      oe1_q <= 1'b0;
      oe2_q <= 1'b0;
    end else begin
      oe1_q <= ovf_oe;
      oe2_q <= oe1_q;
    end
  end
  assign display_blank = !ovf_s & !ovf_oe & !oe1_q & !oe2_q;
endmodule // cbsrp_port

// >>> cbsrp_reader.sv
// Far-side capture logic reading the scanned digits
`timescale 1ns/10ps
// ======
// Reader
module cbsrp_reader (
  input wire logic clk_sys,
  input wire logic scan_clk,
  input wire logic sync_n,
  input wire logic [3:0] bcd,
  output logic [19:0] word_q,
  output logic done_q
);
  logic clk_q = 1'h0;
  logic armed_q = 1'h0;
  logic [2:0] n_q = 3'h0;
  // Only listens; never drives the scan clock line
  always @(posedge clk_sys) begin
    clk_q <= scan_clk;
    done_q <= 1'h0;
    if (!sync_n) begin
      armed_q <= 1'h1;
      n_q <= 3'h0;
    end else if (armed_q && clk_q && !scan_clk) begin
      word_q <= {word_q[15:0], bcd};
      n_q <= n_q + 3'h1;
      if (n_q == 3'h4) begin
        done_q <= 1'h1;
        armed_q <= 1'h0;
      end
    end
  end
endmodule // cbsrp_reader

// >>> cbsrp_port_properties.sv
// Checker of the scanned BCD rear port
`timescale 1ns/10ps
// =======
// Checker
module cbsrp_props (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic gate_end,
  input wire logic tally_mode,
  input wire logic latch_strobe,
  input wire logic clear_in,
  input wire logic clear_oe,
  input wire logic counter_clear,
  input wire logic count_ovf,
  input wire logic zero_supp,
  input wire logic ovf_oe,
  input wire logic ovf_out,
  input wire logic scan_dis_n,
  input wire logic scan_clk_out,
  input wire logic sync_out_n,
  input wire logic [3:0] bcd_out,
  input wire logic [19:0] display_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_go;
    gate_end && !tally_mode && !latch_strobe |=> latch_strobe;
  endproperty
  a_go: assert property (p_go) else $error("strobe late");
  property p_width;
    $rose(latch_strobe) && !tally_mode |->
      latch_strobe[*8] ##1 latch_strobe[*2] ##1 !latch_strobe;
  endproperty
  a_width: assert property (p_width) else $error("strobe width");
  property p_tally; tally_mode[*4] |-> latch_strobe; endproperty
  a_tally: assert property (p_tally) else $error("tally strobe");
  // Power-up pull only; a second reset must pull again
  property p_por; $rose(nrst) |-> clear_oe[*8] ##[6:10] !clear_oe;
  endproperty
  a_por: assert property (p_por) else $error("power-up clear");
  property p_quiet; nrst && $past(nrst) |-> !$rose(clear_oe); endproperty
  a_quiet: assert property (p_quiet) else $error("clear pulled");
  property p_clr; !clear_in[*3] |-> counter_clear; endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_zs; !count_ovf && zero_supp |-> ovf_oe && !ovf_out;
  endproperty
  a_zs: assert property (p_zs) else $error("zero suppress");
  property p_stop; !scan_dis_n[*4] |-> $stable(scan_clk_out); endproperty
  a_stop: assert property (p_stop) else $error("scan runs");
  property p_msd;
    $rose(sync_out_n) && !zero_supp |-> bcd_out == display_q[19:16];
  endproperty
  a_msd: assert property (p_msd) else $error("not msd");
  property p_hold;
    $changed(bcd_out) |-> scan_clk_out && !$past(scan_clk_out, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("digit moved");
  c_strobe: cover property ($rose(latch_strobe));
  c_sync: cover property ($rose(sync_out_n));
  c_clear: cover property (counter_clear);
endmodule // cbsrp_props

bind cbsrp_port cbsrp_props i_cbsrp_props (.*);

// >>> test_counter_scanned_bcd_rear_port.sv
// Self-checking bench for the scanned BCD rear port
`timescale 1ns/10ps
// =====
// Bench
module test_counter_scanned_bcd_rear_port;
  logic clk_sys, nrst, count_ovf, gate_end, tally_mode, zero_supp;
  logic pull_clr, pull_ovf, manual_gate_n, scan_dis_n, int_clear;
  logic [19:0] count_in;
  logic [4:0] dp_active;
  wire clear_out, clear_oe, ovf_out, ovf_oe, fifo_ready, counter_clear;
  wire gate_open, display_blank, scan_clk_out, sync_out_n, latch_strobe;
  wire done_q;
  wire [19:0] display_q, word_q;
  wire [3:0] bcd_out;
  wire [4:0] dp_out_n;
  // Open-drain pins: low while any party pulls
  wire clear_in = !(clear_oe && !clear_out) && !pull_clr;
  wire ovf_in = !(ovf_oe && !ovf_out) && !pull_ovf;
  int errors = 0;
  int checked = 0;
  int n;
  cbsrp_port i_cbsrp_port (.*);
  cbsrp_reader i_cbsrp_reader (
    .clk_sys(clk_sys),
    .scan_clk(scan_clk_out),
    .sync_n(sync_out_n),
    .bcd(bcd_out),
    .word_q(word_q),
    .done_q(done_q)
  );
  task tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task cmp(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t_pins;
    cmp(clear_in, 1'h0);
    cmp(gate_open, 1'h0);
    @(posedge clk_sys);
    zero_supp <= 1'h1;
    dp_active <= 5'h12;
    tick(20);
    cmp(clear_in, 1'h1);
    cmp(ovf_in, 1'h0);
    cmp(display_blank, 1'h0);
    cmp(dp_out_n, 5'h0d);
    @(posedge clk_sys);
    zero_supp <= 1'h0;
    pull_clr <= 1'h1;
    pull_ovf <= 1'h1;
    tick(4);
    cmp(display_blank, 1'h1);
    cmp(counter_clear, 1'h1);
    cmp(clear_oe, 1'h0);
    @(posedge clk_sys);
    pull_clr <= 1'h0;
    pull_ovf <= 1'h0;
    int_clear <= 1'h1;
    tick(4);
    cmp(ovf_in, 1'h1);
    cmp(clear_in, 1'h1);
    cmp(counter_clear, 1'h1);
    @(posedge clk_sys);
    int_clear <= 1'h0;
    tick(4);
    cmp(counter_clear, 1'h0);
  endtask
  task t_store;
    @(posedge clk_sys);
    count_in <= 20'h12345;
    gate_end <= 1'h1;
    @(posedge clk_sys);
    gate_end <= 1'h0;
    #1;
    n = 0;
    while (latch_strobe === 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    cmp(n, 20'ha);
    n = 0;
    while (display_q !== 20'h12345 && n < 20000) begin
      tick(1);
      n++;
    end
    cmp(display_q, 20'h12345);
    n = 0;
    // A whole scan is six slots of 10000 cycles
    while (done_q !== 1'h1 && n < 80000) begin
      tick(1);
      n++;
    end
    cmp(word_q, 20'h12345);
  endtask
  task t_rate;
    n = 0;
    while (scan_clk_out !== 1'h1 && n < 12000) begin
      tick(1);
      n++;
    end
    n = 0;
    while (scan_clk_out === 1'h1 && n < 6000) begin
      tick(1);
      n++;
    end
    cmp(n, 20'h1388);
  endtask
  task t_modes;
    @(posedge clk_sys);
    tally_mode <= 1'h1;
    manual_gate_n <= 1'h0;
    scan_dis_n <= 1'h0;
    tick(5);
    cmp(latch_strobe, 1'h1);
    cmp(gate_open, 1'h1);
    n = scan_clk_out;
    tick(6000);
    cmp(scan_clk_out, n[0]);
    cmp(fifo_ready, 1'h0);
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    {nrst, count_ovf, gate_end, tally_mode, zero_supp, pull_clr} = 6'h0;
    pull_ovf = 1'h0;
    {manual_gate_n, scan_dis_n, int_clear} = 3'h6;
    count_in = 20'h0;
    dp_active = 5'h0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    tick(2);
    t_pins;
    t_store;
    t_rate;
    t_modes;
    end_of_test;
  end
  initial begin
    #4500000;
    errors++;
    end_of_test;
  end
endmodule // test_counter_scanned_bcd_rear_port
